// ==== abn_filter.sv ====
`timescale 1ns/100ps
module abn_filter #(
  parameter int WIDTH = 3,
  parameter int CYC   = 3,
  parameter int CW    = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Raw and filtered levels
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] filt
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= raw;
      sync_ff <= meta_ff;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_ch
      logic [CW-1:0] cnt_ff;
      logic          out_ff;
      // New level must stand CYC clocks before it is taken
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          cnt_ff <= '0;
          out_ff <= 1'b0;
        end else if (sync_ff[i] == out_ff) begin
          cnt_ff <= '0;
        end else if (cnt_ff == CW'(CYC - 1)) begin
          cnt_ff <= '0;
          out_ff <= sync_ff[i];
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
      assign filt[i] = out_ff;
    end
  endgenerate

endmodule

// ==== abn_quadrature_encoder_counter.sv ====
`timescale 1ns/100ps
module abn_quadrature_encoder_counter
  import enc_pkg::*;
#(
  parameter int POS_W = 32
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // Shared pins
  input  wire enc_pkg::abn_type            pins,
  // Configuration
  input  wire logic [1:0]                  global_config,
  input  wire enc_pkg::encoder_config_type encoder_config,
  input  wire logic [enc_pkg::CONST_W-1:0] step_const,
  input  wire logic                        index_enable,
  input  wire logic [POS_W-1:0]            motor_pos,
  input  wire logic [POS_W-1:0]            deviation_limit,
  // Software position write and status clear
  input  wire logic                        pos_load,
  input  wire logic [POS_W-1:0]            pos_load_val,
  input  wire logic                        status_clear,
  // Status
  output logic [POS_W-1:0]                 enc_pos,
  output logic [enc_pkg::FRAC_W-1:0]       enc_frac,
  output logic [POS_W-1:0]                 latch_pos,
  output logic                             clr_status,
  output logic                             latch_status,
  output logic                             dev_irq,
  output logic                             armed
);
  import enc_pkg::*;

  abn_type          routed;
  logic [2:0]       filt;
  logic             a_q;
  logic             b_q;
  logic             n_q;
  logic             a_ff;
  logic             b_ff;
  logic             n_ff;
  logic             prime_ff;
  logic             a_chg;
  logic             b_chg;
  logic             step_ev;
  logic             dir_up;
  logic             idx_ev;
  logic             idx_act;
  logic             do_clr;
  idx_state_type    st_ff;
  idx_state_type    nxt_st;
  logic [POS_W-1:0] pos_ff;
  logic [FRAC_W-1:0] frac_ff;
  logic [POS_W-1:0] nxt_pos;
  logic [FRAC_W-1:0] nxt_frac;
  logic [POS_W-1:0] diff;
  logic             over;

  // Unselected pins held idle so no phantom edges
  always_comb begin
    case (global_config)
      SEL_ENCODER: routed = pins;
      default:     routed = '0;
    endcase
  end

  // Both-edge spike filter after two-flop sync
  abn_filter #(
    .WIDTH (3),
    .CYC   (FILT_CYC),
    .CW    (FILT_W)
  ) u_filt (
    .clk   (clk),
    .reset (reset),
    .raw   ({routed.a, routed.b, routed.n}),
    .filt  (filt)
  );

  // Polarity option, on N only; A and B pass through as filtered
  assign a_q = filt[2];
  assign b_q = filt[1];
  assign n_q = filt[0] ^ encoder_config.pol_n;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      a_ff     <= 1'b0;
      b_ff     <= 1'b0;
      n_ff     <= 1'b0;
      prime_ff <= 1'b0;
    end else begin
      a_ff     <= a_q;
      b_ff     <= b_q;
      n_ff     <= n_q;
      prime_ff <= 1'b1;
    end
  end

  assign a_chg   = prime_ff & (a_q ^ a_ff);
  assign b_chg   = prime_ff & (b_q ^ b_ff);
  assign step_ev = a_chg ^ b_chg;
  // Forward when A changes to differ from B, or B changes to equal A
  always_comb begin
    if (a_chg) begin
      dir_up = a_q ^ b_q;
    end else begin
      dir_up = ~(a_q ^ b_q);
    end
  end

  // Index qualified by A/B levels; unused N simply never fires
  assign idx_ev  = prime_ff & index_enable & n_q & ~n_ff
                   & (encoder_config.ignore_ab
                      | ((a_q == encoder_config.pol_a)
                         & (b_q == encoder_config.pol_b)));

  // Index arming state
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      IDX_OFF: begin
        if (encoder_config.clr_cont) begin
          nxt_st = IDX_CONT;
        end else if (encoder_config.clr_once) begin
          nxt_st = IDX_ARMED;
        end
      end
      IDX_ARMED: begin
        if (encoder_config.clr_cont) begin
          nxt_st = IDX_CONT;
        end else if (!encoder_config.clr_once) begin
          nxt_st = IDX_OFF;
        end else if (idx_ev) begin
          nxt_st = IDX_OFF;
        end
      end
      IDX_CONT: begin
        if (!encoder_config.clr_cont) begin
          nxt_st = IDX_OFF;
        end
      end
      default: nxt_st = IDX_OFF;
    endcase
  end

  // Single shot stays disarmed until clr_once is dropped and set again
  logic once_used_ff;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      once_used_ff <= 1'b0;
    end else if (!encoder_config.clr_once) begin
      once_used_ff <= 1'b0;
    end else if (st_ff == IDX_ARMED && idx_ev) begin
      once_used_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff <= IDX_OFF;
    end else if (st_ff == IDX_OFF && once_used_ff
                 && !encoder_config.clr_cont) begin
      st_ff <= IDX_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign idx_act = idx_ev & (st_ff != IDX_OFF);
  assign do_clr  = idx_act & encoder_config.clr_pos;

  // Signed 16.16 step with fraction carry
  logic [FRAC_W:0]   fsum;
  logic [FRAC_W:0]   fdif;
  logic [FRAC_W-1:0] kfrac;
  logic [POS_W-1:0]  kint;
  always_comb begin
    kfrac    = step_const[FRAC_W-1:0];
    kint     = POS_W'($signed(step_const[CONST_W-1:FRAC_W]));
    fsum     = {1'b0, frac_ff} + {1'b0, kfrac};
    fdif     = {1'b0, frac_ff} - {1'b0, kfrac};
    nxt_pos  = pos_ff;
    nxt_frac = frac_ff;
    if (dir_up) begin
      if (encoder_config.dec_mode) begin
        // Decimal fraction wraps at ten thousand
        if (fsum[FRAC_W-1:0] >= DEC_WRAP) begin
          nxt_frac = FRAC_W'(fsum[FRAC_W-1:0] - DEC_WRAP);
          nxt_pos  = pos_ff + kint + POS_W'(1);
        end else begin
          nxt_frac = fsum[FRAC_W-1:0];
          nxt_pos  = pos_ff + kint;
        end
      end else begin
        nxt_frac = fsum[FRAC_W-1:0];
        nxt_pos  = pos_ff + kint + POS_W'(fsum[FRAC_W]);
      end
    end else begin
      if (fdif[FRAC_W]) begin
        nxt_frac = encoder_config.dec_mode
                   ? FRAC_W'(fdif[FRAC_W-1:0] + DEC_WRAP)
                   : fdif[FRAC_W-1:0];
        nxt_pos  = pos_ff - kint - POS_W'(1);
      end else begin
        nxt_frac = fdif[FRAC_W-1:0];
        nxt_pos  = pos_ff - kint;
      end
    end
  end

  // Position counter; index clear beats a coincident step
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pos_ff  <= '0;
      frac_ff <= '0;
    end else if (pos_load) begin
      pos_ff  <= pos_load_val;
      frac_ff <= '0;
    end else if (do_clr) begin
      pos_ff  <= '0;
      frac_ff <= '0;
    end else if (step_ev) begin
      pos_ff  <= nxt_pos;
      frac_ff <= nxt_frac;
    end
  end

  // Snapshot of position before any coincident clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      latch_pos <= '0;
    end else if (idx_act) begin
      latch_pos <= pos_ff;
    end
  end

  // Sticky clear flag; set wins over clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clr_status <= 1'b0;
    end else if (do_clr) begin
      clr_status <= 1'b1;
    end else if (status_clear) begin
      clr_status <= 1'b0;
    end
  end

  // Sticky snapshot flag; set wins over clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      latch_status <= 1'b0;
    end else if (idx_act) begin
      latch_status <= 1'b1;
    end else if (status_clear) begin
      latch_status <= 1'b0;
    end
  end

  // Deviation check; limit zero disables it
  assign diff = (pos_ff >= motor_pos) ? pos_ff - motor_pos
                                      : motor_pos - pos_ff;
  assign over = (deviation_limit != '0) && (diff > deviation_limit);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dev_irq <= 1'b0;
    end else if (over) begin
      dev_irq <= 1'b1;
    end else if (status_clear) begin
      dev_irq <= 1'b0;
    end
  end

  // Registered readouts, one cycle behind the counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enc_pos <= '0;
    end else begin
      enc_pos <= pos_ff;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enc_frac <= '0;
    end else begin
      enc_frac <= frac_ff;
    end
  end

  // Index action armed
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      armed <= 1'b0;
    end else begin
      armed <= (st_ff != IDX_OFF);
    end
  end

endmodule

// ==== abn_quadrature_encoder_counter_tb_top.sv ====
`timescale 1ns/100ps
module abn_quadrature_encoder_counter_tb_top;
  import enc_pkg::*;
  logic               clk = 1'h0;
  logic               reset = 1'h1;
  abn_type            pins;
  logic [1:0]         global_config = SEL_ENCODER;
  encoder_config_type encoder_config = '0;
  logic [31:0]        step_const = 32'h00010000;
  logic               index_enable = 1'h1;
  logic [31:0]        motor_pos = 32'h0;
  logic [31:0]        deviation_limit = 32'h0;
  logic               pos_load = 1'h0;
  logic [31:0]        pos_load_val = 32'h0;
  logic               status_clear = 1'h0;
  logic               up = 1'h0;
  logic               dn = 1'h0;
  logic               idx = 1'h0;
  logic               spike = 1'h0;
  logic [31:0]        enc_pos, latch_pos;
  logic [15:0]        enc_frac;
  logic               clr_status, latch_status, dev_irq, armed;
  int                 err_total = 0;
  int                 comparisons = 0;

  always #25 clk = ~clk;

  enc_model i_enc (.clk, .reset, .up, .dn, .idx, .spike, .pins);
  abn_quadrature_encoder_counter i_dut (.clk, .reset, .pins,
    .global_config, .encoder_config, .step_const, .index_enable,
    .motor_pos, .deviation_limit, .pos_load, .pos_load_val,
    .status_clear, .enc_pos, .enc_frac, .latch_pos, .clr_status,
    .latch_status, .dev_irq, .armed);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Steps three clocks apart; the filter would pass steps two clocks apart
  task automatic steps(input int n, input logic fwd);
    repeat (n) begin
      up = fwd;
      dn = !fwd;
      cyc(1);
      up = 1'h0;
      dn = 1'h0;
      cyc(2);
    end
    cyc(12);
  endtask
  task automatic load(input logic [31:0] v);
    pos_load = 1'h1;
    pos_load_val = v;
    cyc(1);
    pos_load = 1'h0;
    cyc(2);
  endtask
  task automatic sclr();
    status_clear = 1'h1;
    cyc(1);
    status_clear = 1'h0;
    cyc(2);
  endtask
  task automatic npulse();
    idx = 1'h1;
    cyc(6);
    idx = 1'h0;
    cyc(10);
  endtask

  task automatic t_count();
    load(32'h0);
    steps(4, 1'h1);
    chk(enc_pos, 32'h4);
    steps(2, 1'h0);
    chk(enc_pos, 32'h2);
    step_const = 32'hFFFF0000;
    steps(4, 1'h1);
    chk(enc_pos, 32'hFFFFFFFE);
  endtask
  task automatic t_frac();
    step_const = 32'h00018000;
    load(32'h0);
    steps(3, 1'h1);
    chk(enc_pos, 32'h4);
    chk(enc_frac, 32'h8000);
  endtask
  task automatic t_dec();
    encoder_config.dec_mode = 1'h1;
    step_const = 32'h00011388;
    load(32'h0);
    steps(3, 1'h1);
    chk(enc_pos, 32'h4);
    chk(enc_frac, 32'h1388);
    encoder_config.dec_mode = 1'h0;
    step_const = 32'h00010000;
  endtask
  task automatic t_spike_route();
    spike = 1'h1;
    cyc(2);
    spike = 1'h0;
    cyc(12);
    chk(enc_pos, 32'h4);
    global_config = 2'h0;
    cyc(10);
    steps(2, 1'h1);
    chk(enc_pos, 32'h4);
    steps(2, 1'h0);
    global_config = SEL_ENCODER;
    cyc(10);
  endtask
  task automatic t_once();
    encoder_config.pol_a = 1'h1;
    encoder_config.pol_b = 1'h1;
    encoder_config.clr_once = 1'h1;
    encoder_config.clr_pos = 1'h1;
    sclr();
    load(32'h7);
    chk(armed, 32'h1);
    npulse();
    chk(latch_status, 32'h0);
    steps(2, 1'h1);
    npulse();
    chk(latch_pos, 32'h9);
    chk(enc_pos, 32'h0);
    chk(clr_status, 32'h1);
    chk(latch_status, 32'h1);
    chk(armed, 32'h0);
    load(32'h5);
    npulse();
    chk(enc_pos, 32'h5);
  endtask
  task automatic t_cont();
    encoder_config.clr_once = 1'h0;
    encoder_config.clr_pos = 1'h0;
    encoder_config.clr_cont = 1'h1;
    sclr();
    load(32'h3);
    npulse();
    chk(latch_pos, 32'h3);
    chk(enc_pos, 32'h3);
    steps(4, 1'h1);
    npulse();
    chk(latch_pos, 32'h7);
    chk(clr_status, 32'h0);
    index_enable = 1'h0;
    load(32'h1);
    npulse();
    chk(latch_pos, 32'h7);
    index_enable = 1'h1;
  endtask
  task automatic t_dev();
    deviation_limit = 32'h2;
    load(32'h9);
    cyc(4);
    chk(dev_irq, 32'h1);
    motor_pos = 32'h9;
    cyc(4);
    sclr();
    chk(dev_irq, 32'h0);
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    cyc(20);
    reset = 1'h0;
    cyc(8);
    chk(enc_pos, 32'h0);
    t_count();
    t_frac();
    t_dec();
    t_spike_route();
    t_once();
    t_cont();
    t_dev();
    conclude();
  end
  // Run needs well under a thousand clocks
  initial begin
    #1000000;
    err_total++;
    conclude();
  end
endmodule

// ==== enc_asserts.sv ====
`timescale 1ns/100ps
module enc_asserts
  import enc_pkg::*;
#(
  parameter int POS_W = 32
) (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        reset,
  // Inputs
  input wire enc_pkg::abn_type            pins,
  input wire logic [1:0]                  global_config,
  input wire enc_pkg::encoder_config_type encoder_config,
  input wire logic [POS_W-1:0]            deviation_limit,
  input wire logic                        pos_load,
  input wire logic [POS_W-1:0]            pos_load_val,
  input wire logic                        status_clear,
  // Outputs
  input wire logic [POS_W-1:0]            enc_pos,
  input wire logic [POS_W-1:0]            latch_pos,
  input wire logic                        clr_status,
  input wire logic                        latch_status,
  input wire logic                        dev_irq,
  input wire logic                        armed
);
  logic [3:0] quiet_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Quiet span long enough to drain the input pipeline
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      quiet_ff <= 4'h0;
    end else if ($changed(pins) || $changed(encoder_config) ||
                 $changed(global_config) || pos_load) begin
      quiet_ff <= 4'h0;
    end else if (quiet_ff != 4'hF) begin
      quiet_ff <= quiet_ff + 4'h1;
    end
  end

  sequence s_clr;
    $rose(clr_status);
  endsequence

  property p_clr_zero;
    s_clr |-> ##1 enc_pos == '0;
  endproperty
  a_clr_zero: assert property (p_clr_zero)
    else $error("clear left position");
  property p_clr_cfg;
    s_clr |-> encoder_config.clr_pos;
  endproperty
  a_clr_cfg: assert property (p_clr_cfg)
    else $error("clear without enable");
  property p_latch;
    $rose(latch_status) |-> latch_pos == enc_pos;
  endproperty
  a_latch: assert property (p_latch)
    else $error("snapshot wrong");
  property p_disarm;
    !(encoder_config.clr_once || encoder_config.clr_cont) [*3] |-> !armed;
  endproperty
  a_disarm: assert property (p_disarm)
    else $error("armed with no option");
  property p_load;
    pos_load |-> ##2 enc_pos == $past(pos_load_val, 2);
  endproperty
  a_load: assert property (p_load)
    else $error("load not seen");
  property p_quiet;
    quiet_ff == 4'hF |-> $stable(enc_pos);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("count without edge");
  property p_dev_rise;
    $rose(dev_irq) |-> deviation_limit != '0;
  endproperty
  a_dev_rise: assert property (p_dev_rise)
    else $error("irq with check off");
  property p_dev_fall;
    $fell(dev_irq) |-> $past(status_clear);
  endproperty
  a_dev_fall: assert property (p_dev_fall)
    else $error("irq dropped alone");
  property p_stat_fall;
    $fell(clr_status) |-> $past(status_clear);
  endproperty
  a_stat_fall: assert property (p_stat_fall)
    else $error("status dropped alone");
endmodule

bind abn_quadrature_encoder_counter enc_asserts #(.POS_W(POS_W)) i_chk (
  .clk, .reset, .pins, .global_config, .encoder_config, .deviation_limit,
  .pos_load, .pos_load_val, .status_clear, .enc_pos, .latch_pos,
  .clr_status, .latch_status, .dev_irq, .armed);

// ==== enc_model.sv ====
`timescale 1ns/100ps
module enc_model
  import enc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Requests from bench
  input  wire logic        up,
  input  wire logic        dn,
  input  wire logic        idx,
  input  wire logic        spike,
  // Encoder lines
  output enc_pkg::abn_type pins
);
  logic [1:0] ph_ff;

  // Gray phase; A leads B going up
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ph_ff <= 2'h0;
    end else if (up) begin
      ph_ff <= ph_ff + 2'h1;
    end else if (dn) begin
      ph_ff <= ph_ff - 2'h1;
    end
  end

  // Spike only ever short, never a real step
  assign pins = '{a: ph_ff[1] ^ ph_ff[0] ^ spike, b: ph_ff[1], n: idx};
endmodule

// ==== enc_pkg.sv ====
package enc_pkg;

  // Fixed-point layout of the step constant
  localparam int FRAC_W       = 16;
  localparam int INT_W        = 16;
  localparam int CONST_W      = INT_W + FRAC_W;
  localparam logic [FRAC_W-1:0] DEC_WRAP   = 16'h2710;
  localparam logic [FRAC_W-1:0] DEC_MAXF   = 16'h270F;

  // Spike filter: pulses shorter than this many clocks are dropped
  localparam int FILT_CYC     = 3;
  localparam int FILT_W       = 2;

  // Peripheral selection value in global_config that routes encoder pins
  localparam logic [1:0] SEL_ENCODER = 2'h1;

  // Encoder configuration bits
  typedef struct packed {
    logic pol_a;
    logic pol_b;
    logic pol_n;
    logic ignore_ab;
    logic clr_cont;
    logic clr_once;
    logic clr_pos;
    logic dec_mode;
  } encoder_config_type;

  typedef struct packed {
    logic a;
    logic b;
    logic n;
  } abn_type;

  typedef enum logic [1:0] {
    IDX_OFF    = 2'b00,
    IDX_ARMED  = 2'b01,
    IDX_CONT   = 2'b10
  } idx_state_type;

endpackage
